// ===== tb_top.sv
module tb_top
    import tse_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, resetn, psel, penable, pwrite, countInput, start;
    logic        pready, pslverr, irqRequest;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] expQ[$];
    logic [15:0] lfsrState = 16'h4AFE;
    tse_events_t eventsOut;
    logic [4:0]  evtSeen = 5'h00;
    tse_act_t    acts[3] = '{ACT_RISE, ACT_ANY_EDGE, ACT_HIGH};
    int          edges[3] = '{4, 8, 8};
    int          err_total = 0, compares = 0, cycles = 0;

    tse_timer tse_timer_inst (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .countInput(countInput),
        .eventsOut(eventsOut), .irqRequest(irqRequest));
    tse_event_source tse_event_source_inst (
        .mclk(mclk), .resetn(resetn), .start(start), .countInput(countInput));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic end_of_test();
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    // read data is compared against the oldest note at its ready edge
    always @(posedge mclk) begin
        cycles++;
        // events gathered in flag bit order for a compare against flags
        evtSeen <= evtSeen | {eventsOut.compareMatch,
            eventsOut.highUnderflow, eventsOut.wrapLowUnderflow};
        if (psel && penable && !pwrite && pready === 1'b1) begin
            chk(prdata, expQ.pop_front());
        end
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        {resetn, psel, penable, pwrite, start} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        rd(ADDR_PERIOD, {16'h0, PERIOD_RESET});
        rd(8'h40, 32'h0);
        lfsrState = lfsr(lfsrState);
        wr(ADDR_PERIOD, 32'h5);
        wr(ADDR_CMP_A, {30'h0, lfsrState[1:0]});
        wr(ADDR_CMP_B, 32'h3);
        wr(ADDR_CMP_C, 32'h5);
        wr(ADDR_IRQ_ENABLE, 32'h1F);
        wr(ADDR_CTRL_PRIMARY, 32'h1);
        repeat (40) @(posedge mclk);
        wr(ADDR_CTRL_PRIMARY, 32'h0);
        rd(ADDR_IRQ_FLAG, 32'h1D);
        chk({27'h0, evtSeen}, 32'h1D);
        chk({31'h0, irqRequest}, 32'h1);
        wr(ADDR_IRQ_FLAG, 32'h01);
        rd(ADDR_IRQ_FLAG, 32'h1C);
        wr(ADDR_IRQ_ENABLE, 32'h0);
        repeat (2) @(negedge mclk);
        chk({31'h0, irqRequest}, 32'h0);
        wr(ADDR_IRQ_FLAG, 32'h1F);
        rd(ADDR_IRQ_FLAG, 32'h0);
        // compares parked far away so only counting shows in the flags
        for (int j = 0; j < 3; j++) begin
            wr(ADDR_CMP_A + 8'(8 * j), 32'h8000);
        end
        wr(ADDR_PERIOD, 32'hFFFF);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_COUNT, 32'h10);
            wr(ADDR_INPUT_INPUT_EVENT_CONTROL, {28'h0, acts[i], 1'b1});
            wr(ADDR_CTRL_PRIMARY, 32'h1);
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
            repeat (24) @(posedge mclk);
            wr(ADDR_CTRL_PRIMARY, 32'h0);
            rd(ADDR_COUNT, 32'h10 + 32'(edges[i]));
        end
        wr(ADDR_COUNT, 32'hFFF0);
        wr(ADDR_INPUT_INPUT_EVENT_CONTROL, {28'h0, ACT_DIR, 1'b1});
        wr(ADDR_CTRL_PRIMARY, 32'h1);
        repeat (20) @(posedge mclk);
        wr(ADDR_CTRL_PRIMARY, 32'h0);
        rd(ADDR_IRQ_FLAG, 32'h1);
        wr(ADDR_PERIOD, 32'h0203);
        wr(ADDR_CTRL_PRIMARY, 32'h1);
        wr(ADDR_CMD_SET_PORT, 32'hC);
        wr(ADDR_CTRL_PRIMARY, 32'h0);
        rd(ADDR_PERIOD, 32'h0203);
        wr(ADDR_CMD_SET_PORT, 32'hC);
        rd(ADDR_PERIOD, 32'hFFFF);
        rd(ADDR_INPUT_INPUT_EVENT_CONTROL, 32'h0);
        wr(ADDR_CTRL_SPLIT, 32'h1);
        wr(ADDR_PERIOD, 32'h0305);
        wr(ADDR_CMP_A, 32'h0002);
        wr(ADDR_CMP_B, 32'h0107);
        wr(ADDR_CMP_C, 32'h0400);
        wr(ADDR_IRQ_ENABLE, 32'h1F);
        wr(ADDR_INPUT_INPUT_EVENT_CONTROL, {28'h0, ACT_RISE, 1'b1});
        wr(ADDR_CTRL_PRIMARY, 32'h1);
        repeat (40) @(posedge mclk);
        wr(ADDR_CTRL_PRIMARY, 32'h0);
        rd(ADDR_IRQ_FLAG, 32'h17);
        rd(ADDR_CTRL_SPLIT, 32'h1);
        chk({27'h0, evtSeen}, 32'h1F);
        end_of_test();
    end
endmodule

// ===== tse_event_source.sv
module tse_event_source
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic start,
    output logic      countInput
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] phase_ff;
    // one start gives four pulses, two cycles high and two low, so the
    // level changes slower than the timer's tick only while prescaleSelect is 0
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 4'h0;
        end else if (start || phase_ff != 4'h0) begin
            phase_ff <= phase_ff + 4'h1;
        end
    end
    assign countInput = phase_ff[1];
endmodule

// ===== tse_pkg.sv
package tse_pkg;

    localparam int unsigned CLK_HZ = 40000000;

    // apb byte addresses, one 32-bit word per register
    localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h00;
    localparam logic [7:0] ADDR_CTRL_SPLIT   = 8'h0C;
    localparam logic [7:0] ADDR_CMD_SET_PORT = 8'h14;
    localparam logic [7:0] ADDR_INPUT_INPUT_EVENT_CONTROL = 8'h24;
    localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'h28;
    localparam logic [7:0] ADDR_IRQ_FLAG     = 8'h2C;
    localparam logic [7:0] ADDR_COUNT        = 8'h80;
    localparam logic [7:0] ADDR_PERIOD       = 8'h98;
    localparam logic [7:0] ADDR_CMP_A        = 8'hA0;
    localparam logic [7:0] ADDR_CMP_B        = 8'hA8;
    localparam logic [7:0] ADDR_CMP_C        = 8'hB0;

    // field positions
    localparam int unsigned BIT_ENABLE    = 0;
    localparam int unsigned BIT_PRESCALE_SELECT_LO = 1;
    localparam int unsigned BIT_CNTEN     = 0;
    localparam int unsigned BIT_ACT_LO    = 1;
    localparam int unsigned BIT_CMD_LO    = 2;
    localparam int unsigned BIT_WRAP      = 0;
    localparam int unsigned BIT_HIGH_UNDERFLOW      = 1;
    localparam int unsigned BIT_CMP_LO    = 4;

    localparam logic [1:0]  CMD_HARD_RESET = 2'h3;
    localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
    localparam logic [9:0]  PRESCALE_ZERO  = 10'h000;

    typedef enum logic [2:0] {
        ACT_NONE     = 3'h0,
        ACT_RISE     = 3'h1,
        ACT_ANY_EDGE = 3'h2,
        ACT_HIGH     = 3'h3,
        ACT_DIR      = 3'h4
    } tse_act_t;

    typedef struct packed {
        logic       wrapLowUnderflow;
        logic       highUnderflow;
        logic [2:0] compareMatch;
    } tse_events_t;

endpackage

// ===== tse_timer.sv
// Function
// [RQ1] mode switch reinterprets registers; stored values stay untouched
// [RQ2] software disables and hard-resets before changing mode
// [RQ3] software sets split, writes period, then enables
// [RQ4] enabled counter steps on prescaled ticks; value readable
// [RQ5] wrap/low-underflow event is a one-clock pulse
// [RQ6] high-underflow event pulses only in split mode
// [RQ7] three compare events pulse on match; split uses low bytes
// [RQ8] events fire under the same condition that sets flags
// [RQ9] input action: rising edge, any edge, or while high
// [RQ10] direction action: low counts up, high counts down
// [RQ11] count input used only while its enable bit is one
// [RQ12] split mode ignores the count input
// [RQ13] event source keeps level rate below timer rate; the source changes level every 2 clocks, so only while prescaleSelect is 0
// [RQ14] normal wrap condition at top up, bottom down
// [RQ15] normal compare condition: counter equals 16-bit compare
// [RQ16] split underflows when low or high counter reaches bottom
// [RQ17] split compares low counter to low compare byte only
// [RQ18] each condition sets its flag
// [RQ19] each source has its own enable bit
// [RQ20] request while enable and flag set, until flag cleared
// [RQ21] keeps running in idle sleep
// [RQ22] split counters count down only, single slope
// [RQ23] hard reset restores registers, only while disabled
// [RQ24] write one clears a flag, zero leaves it
module tse_timer
    import tse_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        countInput,
    output tse_events_t      eventsOut,
    output logic             irqRequest
);

    typedef struct packed {
        logic        enable;
        logic [2:0]  prescaleSelect;
        logic        dualByteSelect;
        logic        countInputEnable;
        logic [2:0]  inputActionSelect;
        logic [4:0]  irqEnable;
        logic [4:0]  irqFlag;
        logic [15:0] count;
        logic [15:0] period;
        logic [15:0] cmpA;
        logic [15:0] cmpB;
        logic [15:0] cmpC;
        logic [9:0]  prescale;
        logic        inPrev;
        logic        countDown;
        tse_events_t evt;
        logic        irq;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } tse_state_t;

    tse_state_t st_ff;
    tse_state_t nxt_st;

    logic        tick;
    logic        stepEn;
    logic        wrapHit;
    logic        lowBottom;
    logic        highBottom;
    logic [2:0]  cmpHit;
    logic [4:0]  cond;
    logic [15:0] cmpVal [3];
    logic        wrEn;
    logic        rdEn;
    logic        mapped;

    assign cmpVal[0] = st_ff.cmpA;
    assign cmpVal[1] = st_ff.cmpB;
    assign cmpVal[2] = st_ff.cmpC;

    // prescaler tick: lowest n bits all ones, divider 2^n
    always_comb begin
        case (st_ff.prescaleSelect)
            3'h0: tick = 1'b1;
            3'h1: tick = &st_ff.prescale[0:0];
            3'h2: tick = &st_ff.prescale[1:0];
            3'h3: tick = &st_ff.prescale[2:0];
            3'h4: tick = &st_ff.prescale[3:0];
            3'h5: tick = &st_ff.prescale[5:0];
            3'h6: tick = &st_ff.prescale[7:0];
            default: tick = &st_ff.prescale[9:0];
        endcase
    end

    // count input gating; level actions rely on a slow source  RQ13
    always_comb begin
        stepEn = st_ff.enable & tick; // [RQ4]
        if (st_ff.countInputEnable && !st_ff.dualByteSelect) begin // [RQ11]
            case (tse_act_t'(st_ff.inputActionSelect))
                ACT_RISE:     stepEn = stepEn & countInput & ~st_ff.inPrev; // [RQ9]
                ACT_ANY_EDGE: stepEn = stepEn & (countInput ^ st_ff.inPrev); // [RQ9]
                ACT_HIGH:     stepEn = stepEn & countInput; // [RQ9]
                default:      stepEn = stepEn;
            endcase
        end
    end

    // match conditions; split reinterprets the same stored bits  RQ1
    always_comb begin
        wrapHit    = 1'b0;
        lowBottom  = 1'b0;
        highBottom = 1'b0;
        if (stepEn) begin
            if (st_ff.dualByteSelect) begin
                lowBottom  = st_ff.count[7:0] == 8'h00; // [RQ16]
                highBottom = st_ff.count[15:8] == 8'h00; // [RQ16]
            end else if (st_ff.countDown) begin
                wrapHit = st_ff.count == 16'h0000; // [RQ14]
            end else begin
                wrapHit = st_ff.count == st_ff.period; // [RQ14]
            end
        end
    end

    for (genvar i = 0; i < 3; i++) begin : g_cmp
        assign cmpHit[i] = stepEn & (st_ff.dualByteSelect
            ? st_ff.count[7:0] == cmpVal[i][7:0] // [RQ17] [RQ7]
            : st_ff.count == cmpVal[i]); // [RQ15]
    end

    // one condition vector feeds both flags and events  RQ8
    assign cond = {cmpHit, highBottom, wrapHit | lowBottom};

    assign wrEn   = psel & penable & pwrite & ~st_ff.ready;
    assign rdEn   = psel & penable & ~pwrite & ~st_ff.ready;
    assign mapped = paddr inside {ADDR_CTRL_PRIMARY, ADDR_CTRL_SPLIT,
        ADDR_CMD_SET_PORT, ADDR_INPUT_INPUT_EVENT_CONTROL, ADDR_IRQ_ENABLE,
        ADDR_IRQ_FLAG, ADDR_COUNT, ADDR_PERIOD, ADDR_CMP_A,
        ADDR_CMP_B, ADDR_CMP_C};

    always_comb begin
        nxt_st          = st_ff;
        nxt_st.inPrev   = countInput;
        nxt_st.ready    = 1'b0;
        nxt_st.slverr   = 1'b0;
        // no sleep input: idle sleep never stops the clock here  RQ21
        nxt_st.prescale = st_ff.enable ? st_ff.prescale + 10'h001
                                       : PRESCALE_ZERO;
        if (st_ff.countInputEnable && !st_ff.dualByteSelect // [RQ12]
            && tse_act_t'(st_ff.inputActionSelect) == ACT_DIR) begin
            nxt_st.countDown = countInput; // [RQ10]
        end else begin
            nxt_st.countDown = st_ff.dualByteSelect; // [RQ22]
        end
        if (stepEn) begin
            if (st_ff.dualByteSelect) begin
                // both bytes count down and reload from period bytes  RQ22
                nxt_st.count[7:0] = lowBottom ? st_ff.period[7:0]
                                              : st_ff.count[7:0] - 8'h01;
                nxt_st.count[15:8] = highBottom ? st_ff.period[15:8]
                                                : st_ff.count[15:8] - 8'h01;
            end else if (st_ff.countDown) begin
                nxt_st.count = wrapHit ? st_ff.period
                                       : st_ff.count - 16'h0001;
            end else begin
                nxt_st.count = wrapHit ? 16'h0000 : st_ff.count + 16'h0001;
            end
        end
        nxt_st.evt.wrapLowUnderflow = cond[BIT_WRAP]; // [RQ5]
        nxt_st.evt.highUnderflow    = cond[BIT_HIGH_UNDERFLOW]; // [RQ6]
        nxt_st.evt.compareMatch     = cmpHit; // [RQ7]
        if (wrEn) begin
            case (paddr)
                ADDR_CTRL_PRIMARY: begin
                    nxt_st.enable = pwdata[BIT_ENABLE];
                    nxt_st.prescaleSelect = pwdata[BIT_PRESCALE_SELECT_LO +: 3];
                end
                ADDR_CTRL_SPLIT:   nxt_st.dualByteSelect = pwdata[0];
                // command port is mapped; a write that is ignored is no error
                ADDR_CMD_SET_PORT: nxt_st.slverr = 1'b0;
                ADDR_INPUT_INPUT_EVENT_CONTROL: begin
                    nxt_st.countInputEnable = pwdata[BIT_CNTEN];
                    nxt_st.inputActionSelect = pwdata[BIT_ACT_LO +: 3];
                end
                ADDR_IRQ_ENABLE:   nxt_st.irqEnable = pwdata[4:0]; // [RQ19]
                ADDR_IRQ_FLAG:     nxt_st.irqFlag = st_ff.irqFlag & ~pwdata[4:0]; // [RQ24]
                ADDR_COUNT:        nxt_st.count  = pwdata[15:0];
                ADDR_PERIOD:       nxt_st.period = pwdata[15:0];
                ADDR_CMP_A:        nxt_st.cmpA   = pwdata[15:0];
                ADDR_CMP_B:        nxt_st.cmpB   = pwdata[15:0];
                ADDR_CMP_C:        nxt_st.cmpC   = pwdata[15:0];
                default:           nxt_st.slverr = 1'b1;
            endcase
            if (paddr == ADDR_CMD_SET_PORT && !st_ff.enable
                && pwdata[BIT_CMD_LO +: 2] == CMD_HARD_RESET) begin
                nxt_st = '0; // [RQ23]
                nxt_st.period = PERIOD_RESET; // [RQ23]
            end
        end
        // set wins over a same-cycle clear
        nxt_st.irqFlag = nxt_st.irqFlag | cond; // [RQ18]
        nxt_st.irq = |(nxt_st.irqFlag & nxt_st.irqEnable); // [RQ20]
        if (rdEn) begin
            nxt_st.slverr = ~mapped;
            case (paddr)
                ADDR_CTRL_PRIMARY: nxt_st.rdata = {28'h0000000,
                    st_ff.prescaleSelect, st_ff.enable};
                ADDR_CTRL_SPLIT:   nxt_st.rdata = {31'h00000000,
                    st_ff.dualByteSelect};
                ADDR_INPUT_INPUT_EVENT_CONTROL: nxt_st.rdata = {28'h0000000,
                    st_ff.inputActionSelect, st_ff.countInputEnable};
                ADDR_IRQ_ENABLE:   nxt_st.rdata = {27'h0000000,
                    st_ff.irqEnable};
                ADDR_IRQ_FLAG:     nxt_st.rdata = {27'h0000000,
                    st_ff.irqFlag};
                ADDR_COUNT:        nxt_st.rdata = {16'h0000, st_ff.count}; // [RQ4]
                ADDR_PERIOD:       nxt_st.rdata = {16'h0000, st_ff.period};
                ADDR_CMP_A:        nxt_st.rdata = {16'h0000, st_ff.cmpA};
                ADDR_CMP_B:        nxt_st.rdata = {16'h0000, st_ff.cmpB};
                ADDR_CMP_C:        nxt_st.rdata = {16'h0000, st_ff.cmpC};
                default:           nxt_st.rdata = 32'h00000000;
            endcase
        end
        if (wrEn || rdEn) begin
            nxt_st.ready = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_ff        <= '0;
            st_ff.period <= PERIOD_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata     = st_ff.rdata;
    assign pready     = st_ff.ready;
    assign pslverr    = st_ff.slverr;
    assign eventsOut  = st_ff.evt;
    assign irqRequest = st_ff.irq;

endmodule

// ===== tse_timer_properties.sv
module tse_timer_properties
    import tse_pkg::*;
(
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        countInput,
    input wire tse_events_t eventsOut,
    input wire logic        irqRequest
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    ready_answer_a: assert property (psel && penable && !pready |-> ##[1:2]
        pready) else $error("access not answered");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == '0)
        else $error("refused read not zero");
    cmd_reads_zero_a: assert property (pready && !pwrite &&
        paddr == ADDR_CMD_SET_PORT |-> prdata == '0)
        else $error("command port read not zero");
    cmd_not_refused_a: assert property (pready &&
        paddr == ADDR_CMD_SET_PORT |-> !pslverr)
        else $error("command port access refused");
    irq_rise_a: assert property ($rose(irqRequest) |-> pready ||
        $past(pready) || eventsOut != '0 || $past(eventsOut) != '0)
        else $error("request rose without cause");
    irq_fall_a: assert property ($fell(irqRequest) |-> pready ||
        $past(pready) || $past(pready, 2))
        else $error("request fell without write");
endmodule

bind tse_timer tse_timer_properties tse_timer_properties_inst (
    .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .countInput(countInput),
    .eventsOut(eventsOut), .irqRequest(irqRequest));
